// ===== pkg/ssbm_pkg.sv
// Constants, types and address functions for the sub-CPU buffer memory mapper
package ssbm_pkg;

   // Sub-CPU address map boundaries
   localparam logic [15:0] ADDR_DEAD_LO  = 16'hffc0;
   localparam logic [15:0] ADDR_CS_HI    = 16'hffdf;
   localparam logic [15:0] ADDR_REG_LO   = 16'hff00;
   localparam logic [15:0] ADDR_SEG_LO   = 16'he000;
   localparam logic [15:0] ADDR_PAGE2_LO = 16'hd000;
   localparam logic [15:0] ADDR_FAST_LO  = 16'hc000;

   // Register offsets
   localparam logic [15:0] OFF_PAGE1_HIGH = 16'hff18;
   localparam logic [15:0] OFF_PAGE1_LOW  = 16'hff19;
   localparam logic [15:0] OFF_PAGE2_HIGH = 16'hff1a;
   localparam logic [15:0] OFF_PAGE2_LOW  = 16'hff1b;
   localparam logic [15:0] OFF_SEG_LOW8   = 16'hff1c;
   localparam logic [15:0] OFF_SEG_HIGH4  = 16'hff1d;
   localparam logic [15:0] OFF_DRAM_SETUP = 16'hff6a;

   // Implemented bits of each register
   localparam logic [7:0] MASK_PAGE1_LOW  = 8'hfc;
   localparam logic [7:0] MASK_PAGE2_LOW  = 8'hf4;
   localparam logic [7:0] MASK_SEG_HIGH4  = 8'h0f;
   localparam logic [7:0] MASK_DRAM_SETUP = 8'h1f;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [7:0] READ_ZERO       = 8'h00;

   // DRAM setup field positions
   localparam int CFG_REFRESH_BIT = 4;
   localparam int CFG_RAS_BIT     = 3;
   localparam int CFG_ORG_X4_BIT  = 2;
   localparam int CFG_ORG_4M_BIT  = 1;
   localparam int CFG_HYPER_BIT   = 0;

   // Timing counts in system clocks
   localparam logic [8:0] REFRESH_SHORT_CYC = 9'h100;
   localparam logic [8:0] REFRESH_LONG_CYC  = 9'h1ff;
   localparam logic [8:0] COUNT_ONE         = 9'h001;
   localparam logic [1:0] RAS_SHORT_CYC     = 2'h2;
   localparam logic [1:0] RAS_LONG_CYC      = 2'h3;
   localparam logic [1:0] STRAP_WAIT_CYC    = 2'h3;

   // Segment size in bytes
   localparam logic [23:0] SEG_BYTES = 24'h000a00;

   typedef enum logic [2:0] {
      RGN_PAGE1 = 3'h0,
      RGN_PAGE2 = 3'h1,
      RGN_SEG   = 3'h2,
      RGN_REG   = 3'h3,
      RGN_DEAD  = 3'h4
   } ssbm_region_t;

   // Gray sequence along idle, address, strobe, done
   typedef enum logic [1:0] {
      CYC_IDLE   = 2'b00,
      CYC_ADDR   = 2'b01,
      CYC_STROBE = 2'b11,
      CYC_DONE   = 2'b10
   } ssbm_cycle_t;

   function automatic ssbm_region_t decode_region(input logic [15:0] a);
      if (a >= ADDR_DEAD_LO)
         decode_region = RGN_DEAD;
      else if (a >= ADDR_REG_LO)
         decode_region = RGN_REG;
      else if (a >= ADDR_SEG_LO)
         decode_region = RGN_SEG;
      else if (a >= ADDR_PAGE2_LO)
         decode_region = RGN_PAGE2;
      else
         decode_region = RGN_PAGE1;
   endfunction : decode_region

   // Buffer address of a sub-CPU address
   function automatic logic [23:0] map_addr(input logic [15:0] a,
                                            input logic [15:0] p1,
                                            input logic [15:0] p2,
                                            input logic [11:0] seg);
      logic [13:0] hi;
      hi = 14'h0000;
      case (decode_region(a))
         RGN_PAGE1: begin
            hi = p1[15:2] + {8'h00, a[15:10]};
            map_addr = {hi, a[9:0]};
         end
         RGN_PAGE2: begin
            hi = p2[15:2] + {12'h000, a[11:10]};
            map_addr = {hi, a[9:0]};
         end
         RGN_SEG: begin
            // No upper limit: three whole segments always follow the base
            map_addr = {12'h000, seg} * SEG_BYTES + {11'h000, a[12:0]};
         end
         default: begin
            map_addr = {16'h0000, a[7:0]};
         end
      endcase
   endfunction : map_addr

endpackage : ssbm_pkg

// ===== verilog/ssbm_pin_sync.sv
// Two-flop synchroniser with edge detection for asynchronous pins
`timescale 1ns/1ns
module ssbm_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // Raw pins
   input  wire logic [W-1:0] d,
   // Synchronised level and edges
   output logic      [W-1:0] q,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   // Edges look only at the second and third stages
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign q    = sync_reg;
   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;

endmodule : ssbm_pin_sync

// ===== verilog/ssbm_mapper.sv
// Sub-CPU external data space mapper, register file and DRAM setup
// What this block does
// - Dead zone FFC0-FFFF starts no DRAM access and keeps data output disabled.
// - Generic host mode drives chip-select pin low for FFC0-FFDF accesses.
// - Reads in register region return page and segment registers, zero for other offsets (DRAM setup included), never DRAM data.
// - Register writes update registers; with debug set they also go to DRAM.
// - Register region DRAM address is zero above bit 7, low byte passed.
// - Segment window address is base times 2560 plus low thirteen bits.
// - Segment window spans three whole segments plus 256 bytes with no upper limit check.
// - Page two address adds offset bits 15..2 to address bits 11..10.
// - Page one address adds offset bits 15..2 to address bits 15..10.
// - Page offsets move in 1024-byte steps (page two has no 2048-byte bit) and pages may overlap.
// - Fast mode makes the lowest 48 kbytes of page one inaccessible.
// - Page two is mapped and accessible in every access mode.
// - Refresh every 256 clocks when bit clear, 511 when set.
// - RAS low minimum is 2 clocks when bit set, 3 when clear.
// - Organisation bits select 1 Mbit x4, 4 Mbit x4 or any x8.
// - Page mode bit selects fast-page when clear, hyper-page when set.
// - Fast mode starts RAM cycle at address strobe fall, none below C000.
// - Slow mode starts RAM cycle at read/write fall, only with store enable high.
`timescale 1ns/1ns
module ssbm_mapper (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Sub-CPU multiplexed bus pins
   input  wire logic [7:0]  external_data_bus_in,
   output logic      [7:0]  external_data_bus_out,
   output logic             external_data_bus_oe,
   input  wire logic [7:0]  addr_high,
   input  wire logic        ale,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        program_store_enable_n,
   output logic             dead_zone_chip_select_pin_n,
   // Mode levels from on-chip control logic
   input  wire logic        generic_mode,
   input  wire logic        fast_access_mode,
   input  wire logic        debug_write_en,
   // Strap result
   output logic             mcu_bus_mode,
   // DRAM cycle engine request
   output logic             dram_req,
   output logic             dram_we,
   output logic      [23:0] dram_addr,
   output logic      [7:0]  dram_wdata,
   input  wire logic        dram_ack,
   input  wire logic [7:0]  dram_rdata,
   // DRAM interface setup
   output logic             refresh_req,
   output logic      [1:0]  ras_min_low_cycles,
   output logic             org_x4,
   output logic             org_4mbit,
   output logic             hyper_page_mode
);

   logic [3:0]  strobe_q;
   logic [3:0]  strobe_rise;
   logic [3:0]  strobe_fall;
   logic [15:0] bus_q;

   logic [15:0] addr_reg;
   logic [7:0]  page1_high_reg;
   logic [7:0]  page1_low_reg;
   logic [7:0]  page2_high_reg;
   logic [7:0]  page2_low_reg;
   logic [7:0]  seg_low8_reg;
   logic [7:0]  seg_high4_reg;
   logic [7:0]  dram_setup_reg;
   logic [7:0]  rd_data_reg;
   logic        oe_reg;
   logic        cs_n_reg;
   logic        read_pending_reg;
   logic [8:0]  refresh_cnt_reg;
   logic [1:0]  strap_cnt_reg;
   logic        strap_done_reg;
   logic        mcu_bus_mode_reg;
   logic        dram_req_reg;
   logic        dram_we_reg;
   logic [23:0] dram_addr_reg;
   logic [7:0]  dram_wdata_reg;

   ssbm_pkg::ssbm_cycle_t  cyc_reg;
   ssbm_pkg::ssbm_cycle_t  cyc_next;
   ssbm_pkg::ssbm_region_t rgn;

   logic        ale_fall;
   logic        rd_fall;
   logic        rd_rise;
   logic        wr_fall;
   logic        wr_rise;
   logic        store_enable_high;
   logic [15:0] cur_addr;
   logic [23:0] cur_map;
   logic [15:0] page1_base;
   logic [15:0] page2_base;
   logic [11:0] seg_base;
   logic        rd_take;
   logic        wr_take;

   // Address may sit in the reset range of the RAM; RAM-backed page one below C000 is not accessible in fast mode
   function automatic logic dram_area(input logic [15:0] a, input logic fast);
      ssbm_pkg::ssbm_region_t r;
      r = ssbm_pkg::decode_region(a);
      dram_area = (r == ssbm_pkg::RGN_PAGE1 || r == ssbm_pkg::RGN_PAGE2 || r == ssbm_pkg::RGN_SEG)
                  && (!fast || a >= ssbm_pkg::ADDR_FAST_LO);
   endfunction : dram_area

   ssbm_pin_sync #(
      .W (4)
   ) u_strobe_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({ale, rd_n, wr_n, program_store_enable_n}),
      .q    (strobe_q),
      .rise (strobe_rise),
      .fall (strobe_fall)
   );

   // Bus is sampled well after it settles, so per-bit skew does not matter
   ssbm_pin_sync #(
      .W (16)
   ) u_bus_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({addr_high, external_data_bus_in}),
      .q    (bus_q),
      .rise (),
      .fall ()
   );

   assign ale_fall          = strobe_fall[3];
   assign rd_fall           = strobe_fall[2];
   assign rd_rise           = strobe_rise[2];
   assign wr_fall           = strobe_fall[1];
   assign wr_rise           = strobe_rise[1];
   assign store_enable_high = strobe_q[0];

   assign page1_base = {page1_high_reg, page1_low_reg};
   assign page2_base = {page2_high_reg, page2_low_reg};
   assign seg_base   = {seg_high4_reg[3:0], seg_low8_reg};

   // Fast mode needs the address in the very cycle of the latch edge
   assign cur_addr = ale_fall ? bus_q : addr_reg;
   assign cur_map  = ssbm_pkg::map_addr(cur_addr, page1_base, page2_base, seg_base);
   assign rgn      = ssbm_pkg::decode_region(addr_reg);

   assign rd_take = rd_fall && cyc_reg == ssbm_pkg::CYC_ADDR;
   assign wr_take = wr_fall && cyc_reg == ssbm_pkg::CYC_ADDR;

   // Bus cycle tracking
   always_comb begin
      cyc_next = cyc_reg;
      case (cyc_reg)
         ssbm_pkg::CYC_IDLE: begin
            if (ale_fall)
               cyc_next = ssbm_pkg::CYC_ADDR;
         end
         ssbm_pkg::CYC_ADDR: begin
            if (ale_fall)
               cyc_next = ssbm_pkg::CYC_ADDR;
            else if (rd_fall || wr_fall)
               cyc_next = ssbm_pkg::CYC_STROBE;
         end
         ssbm_pkg::CYC_STROBE: begin
            if (rd_rise || wr_rise)
               cyc_next = ssbm_pkg::CYC_DONE;
         end
         ssbm_pkg::CYC_DONE: begin
            cyc_next = ale_fall ? ssbm_pkg::CYC_ADDR : ssbm_pkg::CYC_IDLE;
         end
         default: begin
            cyc_next = ssbm_pkg::CYC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst)
         cyc_reg <= ssbm_pkg::CYC_IDLE;
      else
         cyc_reg <= cyc_next;
   end

   always_ff @(posedge clk) begin
      if (srst)
         addr_reg <= 16'h0000;
      else if (ale_fall)
         addr_reg <= bus_q;
   end

   // Register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         page1_high_reg <= ssbm_pkg::RESET_BYTE;
         page1_low_reg  <= ssbm_pkg::RESET_BYTE;
         page2_high_reg <= ssbm_pkg::RESET_BYTE;
         page2_low_reg  <= ssbm_pkg::RESET_BYTE;
         seg_low8_reg   <= ssbm_pkg::RESET_BYTE;
         seg_high4_reg  <= ssbm_pkg::RESET_BYTE;
         dram_setup_reg <= ssbm_pkg::RESET_BYTE;
      end else if (wr_take && rgn == ssbm_pkg::RGN_REG) begin
         case (addr_reg)
            ssbm_pkg::OFF_PAGE1_HIGH: page1_high_reg <= bus_q[7:0];
            ssbm_pkg::OFF_PAGE1_LOW:  page1_low_reg  <= bus_q[7:0] & ssbm_pkg::MASK_PAGE1_LOW;
            ssbm_pkg::OFF_PAGE2_HIGH: page2_high_reg <= bus_q[7:0];
            ssbm_pkg::OFF_PAGE2_LOW:  page2_low_reg  <= bus_q[7:0] & ssbm_pkg::MASK_PAGE2_LOW;
            ssbm_pkg::OFF_SEG_LOW8:   seg_low8_reg   <= bus_q[7:0];
            ssbm_pkg::OFF_SEG_HIGH4:  seg_high4_reg  <= bus_q[7:0] & ssbm_pkg::MASK_SEG_HIGH4;
            ssbm_pkg::OFF_DRAM_SETUP: dram_setup_reg <= bus_q[7:0] & ssbm_pkg::MASK_DRAM_SETUP;
            default: begin
            end
         endcase
      end
   end

   // DRAM requests
   always_ff @(posedge clk) begin
      if (srst) begin
         dram_req_reg   <= 1'b0;
         dram_we_reg    <= 1'b0;
         dram_addr_reg  <= 24'h000000;
         dram_wdata_reg <= 8'h00;
      end else begin
         dram_req_reg <= 1'b0;
         if (wr_take && store_enable_high &&
             (dram_area(addr_reg, fast_access_mode) ||
              (rgn == ssbm_pkg::RGN_REG && debug_write_en))) begin
            dram_req_reg   <= 1'b1;
            dram_we_reg    <= 1'b1;
            dram_addr_reg  <= cur_map;
            dram_wdata_reg <= bus_q[7:0];
         end else if (ale_fall && fast_access_mode && dram_area(bus_q, 1'b1)) begin
            // Opened before the direction is known; it aborts other buffer traffic
            dram_req_reg  <= 1'b1;
            dram_we_reg   <= 1'b0;
            dram_addr_reg <= cur_map;
         end else if (rd_take && !fast_access_mode && store_enable_high &&
                      dram_area(addr_reg, 1'b0)) begin
            dram_req_reg  <= 1'b1;
            dram_we_reg   <= 1'b0;
            dram_addr_reg <= cur_map;
         end
      end
   end

   // Read data path
   always_ff @(posedge clk) begin
      if (srst) begin
         read_pending_reg <= 1'b0;
         rd_data_reg      <= 8'h00;
      end else begin
         if (dram_req_reg && !dram_we_reg)
            read_pending_reg <= 1'b1;
         else if (dram_ack)
            read_pending_reg <= 1'b0;
         if (rd_take && rgn == ssbm_pkg::RGN_REG) begin
            case (addr_reg)
               ssbm_pkg::OFF_PAGE1_HIGH: rd_data_reg <= page1_high_reg;
               ssbm_pkg::OFF_PAGE1_LOW:  rd_data_reg <= page1_low_reg;
               ssbm_pkg::OFF_PAGE2_HIGH: rd_data_reg <= page2_high_reg;
               ssbm_pkg::OFF_PAGE2_LOW:  rd_data_reg <= page2_low_reg;
               ssbm_pkg::OFF_SEG_LOW8:   rd_data_reg <= seg_low8_reg;
               ssbm_pkg::OFF_SEG_HIGH4:  rd_data_reg <= seg_high4_reg;
               default:                  rd_data_reg <= ssbm_pkg::READ_ZERO;
            endcase
         end else if (read_pending_reg && dram_ack && rgn != ssbm_pkg::RGN_REG) begin
            rd_data_reg <= dram_rdata;
         end
      end
   end

   // Output enable and dead-zone chip select
   always_ff @(posedge clk) begin
      if (srst) begin
         oe_reg   <= 1'b0;
         cs_n_reg <= 1'b1;
      end else begin
         if (rd_take)
            oe_reg <= rgn == ssbm_pkg::RGN_REG || dram_area(addr_reg, fast_access_mode);
         else if (rd_rise || ale_fall)
            oe_reg <= 1'b0;
         cs_n_reg <= !(generic_mode && cyc_next == ssbm_pkg::CYC_STROBE &&
                       addr_reg >= ssbm_pkg::ADDR_DEAD_LO && addr_reg <= ssbm_pkg::ADDR_CS_HI);
      end
   end

   // Refresh pacing
   always_ff @(posedge clk) begin
      if (srst) begin
         refresh_cnt_reg <= ssbm_pkg::REFRESH_SHORT_CYC - ssbm_pkg::COUNT_ONE;
         refresh_req     <= 1'b0;
      end else if (refresh_cnt_reg == 9'h000) begin
         refresh_req     <= 1'b1;
         refresh_cnt_reg <= (dram_setup_reg[ssbm_pkg::CFG_REFRESH_BIT] ? ssbm_pkg::REFRESH_LONG_CYC
                             : ssbm_pkg::REFRESH_SHORT_CYC) - ssbm_pkg::COUNT_ONE;
      end else begin
         refresh_req     <= 1'b0;
         refresh_cnt_reg <= refresh_cnt_reg - ssbm_pkg::COUNT_ONE;
      end
   end

   // Strap sampled once the synchroniser holds real pin values
   always_ff @(posedge clk) begin
      if (srst) begin
         strap_cnt_reg    <= 2'h0;
         strap_done_reg   <= 1'b0;
         mcu_bus_mode_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         if (strap_cnt_reg == ssbm_pkg::STRAP_WAIT_CYC) begin
            strap_done_reg   <= 1'b1;
            mcu_bus_mode_reg <= bus_q[7:0] == 8'h00;
         end else begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
         end
      end
   end

   assign external_data_bus_out       = rd_data_reg;
   assign external_data_bus_oe        = oe_reg;
   assign dead_zone_chip_select_pin_n = cs_n_reg;
   assign mcu_bus_mode                = mcu_bus_mode_reg;
   assign dram_req                    = dram_req_reg;
   assign dram_we                     = dram_we_reg;
   assign dram_addr                   = dram_addr_reg;
   assign dram_wdata                  = dram_wdata_reg;
   assign ras_min_low_cycles = dram_setup_reg[ssbm_pkg::CFG_RAS_BIT] ? ssbm_pkg::RAS_SHORT_CYC
                               : ssbm_pkg::RAS_LONG_CYC;
   assign org_x4          = dram_setup_reg[ssbm_pkg::CFG_ORG_X4_BIT];
   assign org_4mbit       = dram_setup_reg[ssbm_pkg::CFG_ORG_X4_BIT] &
                            dram_setup_reg[ssbm_pkg::CFG_ORG_4M_BIT];
   assign hyper_page_mode = dram_setup_reg[ssbm_pkg::CFG_HYPER_BIT];

endmodule : ssbm_mapper

// ===== tb/ssbm_mapper_chk.sv
// Concurrent checks on the mapper top-level ports
`timescale 1ns/1ns
module ssbm_mapper_chk (
   // Clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // Sub-CPU bus pins
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic       program_store_enable_n,
   input wire logic       generic_mode,
   input wire logic       external_data_bus_oe,
   input wire logic       dead_zone_chip_select_pin_n,
   // DRAM side
   input wire logic       dram_req,
   input wire logic       dram_we,
   input wire logic       refresh_req,
   input wire logic [1:0] ras_min_low_cycles,
   input wire logic       org_x4,
   input wire logic       org_4mbit,
   input wire logic       hyper_page_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   logic [9:0] gap_reg;
   logic       first_reg;

   // First period after reset has no exact gap
   always_ff @(posedge clk) begin
      if (srst) begin
         gap_reg   <= 10'h000;
         first_reg <= 1'b1;
      end else if (refresh_req) begin
         gap_reg   <= 10'h001;
         first_reg <= 1'b0;
      end else begin
         gap_reg <= gap_reg + 10'h001;
      end
   end

   chk_dead_no_drive: assert property (!dead_zone_chip_select_pin_n |-> !external_data_bus_oe)
      else $error("bus driven in dead zone");
   chk_cs_generic_only: assert property (!dead_zone_chip_select_pin_n |-> $past(generic_mode))
      else $error("chip select outside generic mode");
   chk_setup_reset: assert property ($past(srst) |->
      {ras_min_low_cycles, org_x4, org_4mbit, hyper_page_mode} == 5'h18)
      else $error("setup wrong after reset");
   chk_refresh_gap: assert property (refresh_req && !first_reg |-> gap_reg == 10'h100 || gap_reg == 10'h1ff)
      else $error("refresh spacing wrong");
   chk_refresh_bound: assert property (gap_reg < 10'h208)
      else $error("refresh overdue");
   chk_req_pulse: assert property (dram_req |=> !dram_req)
      else $error("dram request too long");
   chk_req_store_high: assert property (dram_req |-> $past(program_store_enable_n, 3))
      else $error("dram request in program fetch");
   chk_drive_on_read: assert property ($rose(external_data_bus_oe) |-> !rd_n)
      else $error("bus driven without read");
   chk_drive_release: assert property ($rose(rd_n) |-> ##[1:6] !external_data_bus_oe)
      else $error("bus not released after read");
   chk_write_req_strobe: assert property (dram_req && dram_we |-> !wr_n)
      else $error("dram write without strobe");

   cov_dead_cs: cover property (!dead_zone_chip_select_pin_n);
   cov_dram_write: cover property (dram_req && dram_we);
   cov_refresh: cover property (refresh_req && !first_reg);
endmodule : ssbm_mapper_chk

bind ssbm_mapper ssbm_mapper_chk ssbm_mapper_chk_inst (
   .clk(clk), .srst(srst), .rd_n(rd_n), .wr_n(wr_n),
   .program_store_enable_n(program_store_enable_n), .generic_mode(generic_mode),
   .external_data_bus_oe(external_data_bus_oe), .dead_zone_chip_select_pin_n(dead_zone_chip_select_pin_n),
   .dram_req(dram_req), .dram_we(dram_we), .refresh_req(refresh_req),
   .ras_min_low_cycles(ras_min_low_cycles), .org_x4(org_x4), .org_4mbit(org_4mbit),
   .hyper_page_mode(hyper_page_mode)
);

// ===== tb/ssbm_mcu_model.sv
// Behavioural sub-CPU driving the multiplexed bus
`timescale 1ns/1ns
module ssbm_mcu_model (
   // Clock
   input wire logic       clk,
   // Block side of the data bus
   input wire logic [7:0] dut_out,
   input wire logic       dut_oe,
   // Bus pins
   output logic     [7:0] ad_bus,
   output logic     [7:0] addr_high,
   output logic           ale,
   output logic           rd_n,
   output logic           wr_n,
   output logic           program_store_enable_n
);
   logic [7:0] drv;
   logic       drv_oe;
   logic [7:0] last;

   // Zeros through reset pick the microcontroller bus
   initial begin
      drv = 8'h00;
      drv_oe = 1'b1;
      ale = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr_high = 8'h00;
      program_store_enable_n = 1'b1;
      last = 8'h00;
   end

   // No pull on this bus: a floating wire toggles every cycle
   always_comb ad_bus = dut_oe ? dut_out : (drv_oe ? drv : ~last);
   always_ff @(posedge clk) last <= ad_bus;

   task automatic addr_phase(input logic [15:0] a);
      ale       = 1'b1;
      addr_high = a[15:8];
      drv       = a[7:0];
      drv_oe    = 1'b1;
      repeat (4) @(negedge clk);
      ale = 1'b0;
      repeat (4) @(negedge clk);
   endtask : addr_phase

   task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
      addr_phase(a);
      drv = d;
      repeat (3) @(negedge clk);
      wr_n = 1'b0;
      repeat (6) @(negedge clk);
      wr_n = 1'b1;
      drv_oe = 1'b0;
      repeat (4) @(negedge clk);
   endtask : bus_write

   task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
      addr_phase(a);
      drv_oe = 1'b0;
      repeat (2) @(negedge clk);
      rd_n = 1'b0;
      repeat (12) @(negedge clk);
      d    = ad_bus;
      rd_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask : bus_read
endmodule : ssbm_mcu_model

// ===== tb/ssbm_mapper_test.sv
// Self-checking bench for the sub-CPU memory mapper
`timescale 1ns/1ns
module ssbm_mapper_test;
   logic        clk, srst, generic_mode, fast_access_mode, debug_write_en;
   logic [7:0]  ad_bus, ad_out, addr_high, dram_wdata, dram_rdata, d;
   logic        ad_oe, ale, rd_n, wr_n, store_n, cs_n, mcu_bus_mode;
   logic        dram_req, dram_we, dram_ack = 1'b0, refresh_req, org_x4, org_4mbit, hyper;
   logic [1:0]  ras, ack_pipe = 2'b00;
   logic [23:0] dram_addr, req_addr = 24'h000000;
   logic [7:0]  req_data;
   logic        req_we;
   int          mismatches, n_tests, cycles, n_req, cs_cnt, oe_cnt, ref_cnt, ref_gap, last_ref, r0, c0, o0;

   localparam logic [15:0] REG_A [8] = '{16'hff18, 16'hff19, 16'hff1a, 16'hff1b, 16'hff1c, 16'hff1d, 16'hff6a, 16'hff00};
   localparam logic [7:0]  REG_W [8] = '{8'h12, 8'h37, 8'h56, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
   localparam logic [7:0]  REG_R [8] = '{8'h12, 8'h34, 8'h56, 8'h74, 8'hff, 8'h0f, 8'h00, 8'h00};
   localparam logic [7:0]  SET_V [4] = '{8'h1f, 8'h0c, 8'h06, 8'h00};
   localparam logic [4:0]  SET_E [4] = '{5'h17, 5'h14, 5'h1e, 5'h18};
   localparam logic [15:0] MAP_A [6] = '{16'h0400, 16'hcfff, 16'hd000, 16'hdfff, 16'he000, 16'hfeff};
   localparam logic [23:0] MAP_E [6] = '{24'h123800, 24'h1303ff, 24'h567400, 24'h5683ff, 24'h9ff600, 24'ha014ff};

   ssbm_mapper ssbm_mapper_inst (
      .clk(clk), .srst(srst), .external_data_bus_in(ad_bus), .external_data_bus_out(ad_out),
      .external_data_bus_oe(ad_oe), .addr_high(addr_high), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .program_store_enable_n(store_n), .dead_zone_chip_select_pin_n(cs_n), .generic_mode(generic_mode),
      .fast_access_mode(fast_access_mode), .debug_write_en(debug_write_en), .mcu_bus_mode(mcu_bus_mode),
      .dram_req(dram_req), .dram_we(dram_we), .dram_addr(dram_addr), .dram_wdata(dram_wdata),
      .dram_ack(dram_ack), .dram_rdata(dram_rdata), .refresh_req(refresh_req),
      .ras_min_low_cycles(ras), .org_x4(org_x4), .org_4mbit(org_4mbit), .hyper_page_mode(hyper));

   ssbm_mcu_model mcu (
      .clk(clk), .dut_out(ad_out), .dut_oe(ad_oe), .ad_bus(ad_bus), .addr_high(addr_high),
      .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .program_store_enable_n(store_n));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // DRAM engine stand-in; read data follows the address
   assign dram_rdata = req_addr[7:0] ^ 8'ha5;
   always @(negedge clk) begin
      cycles++;
      if (dram_req) begin
         n_req++;
         req_addr = dram_addr;
         req_we   = dram_we;
         req_data = dram_wdata;
      end
      ack_pipe = {ack_pipe[0], dram_req & ~dram_we};
      dram_ack = ack_pipe[1];
      cs_cnt += int'(!cs_n);
      oe_cnt += int'(ad_oe);
      if (refresh_req) begin
         ref_cnt++;
         ref_gap  = cycles - last_ref;
         last_ref = cycles;
      end
      if (cycles > 8000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [32:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic snap();
      r0 = n_req;
      c0 = cs_cnt;
      o0 = oe_cnt;
   endtask : snap

   task automatic wait_refresh(input int n);
      int start = ref_cnt;
      for (int i = 0; i < 1200 && ref_cnt < start + n; i++) @(negedge clk);
   endtask : wait_refresh

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      srst             = 1'b1;
      generic_mode     = 1'b0;
      fast_access_mode = 1'b0;
      debug_write_en   = 1'b0;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      repeat (10) @(negedge clk);
      check(33'(mcu_bus_mode), 33'h1);
      check(33'({ras, org_x4, org_4mbit, hyper}), 33'h18);
      for (int i = 0; i < 8; i++) begin
         snap();
         mcu.bus_write(REG_A[i], REG_W[i]);
         mcu.bus_read(REG_A[i], d);
         check(33'(d), 33'(REG_R[i]));
         check(33'(n_req - r0), 33'h0);
      end
      for (int i = 0; i < 4; i++) begin
         mcu.bus_write(16'hff6a, SET_V[i]);
         check(33'({ras, org_x4, org_4mbit, hyper}), 33'(SET_E[i]));
      end
      mcu.bus_write(16'hff6a, 8'h10);
      wait_refresh(2);
      check(33'(ref_gap), 33'h1ff);
      mcu.bus_write(16'hff6a, 8'h00);
      wait_refresh(2);
      check(33'(ref_gap), 33'h100);
      for (int i = 0; i < 6; i++) begin
         snap();
         mcu.bus_write(MAP_A[i], 8'(i + 8'h40));
         check({req_we, req_addr, req_data}, {1'b1, MAP_E[i], 8'(i + 8'h40)});
         mcu.bus_read(MAP_A[i], d);
         check(33'(n_req - r0), 33'h2);
         check({req_we, req_addr, d}, {1'b0, MAP_E[i], MAP_E[i][7:0] ^ 8'ha5});
      end
      debug_write_en = 1'b1;
      snap();
      mcu.bus_write(16'hff1c, 8'hff);
      check({req_we, req_addr, 8'(n_req - r0)}, {1'b1, 24'h00001c, 8'h01});
      debug_write_en = 1'b0;
      generic_mode   = 1'b1;
      snap();
      mcu.bus_read(16'hffc5, d);
      check(33'(cs_cnt > c0), 33'h1);
      check(33'(oe_cnt - o0 + n_req - r0), 33'h0);
      snap();
      mcu.bus_write(16'hffe0, 8'h11);
      check(33'(cs_cnt - c0 + n_req - r0), 33'h0);
      generic_mode = 1'b0;
      snap();
      mcu.bus_read(16'hffc5, d);
      check(33'(cs_cnt - c0), 33'h0);
      fast_access_mode = 1'b1;
      snap();
      mcu.bus_read(16'h1000, d);
      check(33'(n_req - r0), 33'h0);
      snap();
      mcu.bus_read(16'hc400, d);
      check(33'({req_addr, d}), 33'({24'h12f800, 8'ha5}));
      check(33'(n_req - r0), 33'h1);
      mcu.bus_read(16'hd000, d);
      check(33'({req_addr, d}), 33'({24'h567400, 8'h00 ^ 8'ha5}));
      fast_access_mode = 1'b0;
      mcu.program_store_enable_n = 1'b0;
      snap();
      mcu.bus_read(16'h0400, d);
      check(33'(n_req - r0), 33'h0);
      mcu.program_store_enable_n = 1'b1;
      tally_and_finish();
   end
endmodule : ssbm_mapper_test
